// ---- core/pm_power_mode_controller.sv ----
// Power mode controller: modes, push-button, reset and host timers.
`timescale 1ns/1ns
// Functional notes
// (RQ1) Ship mode holds until input valid or wake.
// (RQ2) Host drives charge-disable high for ship mode.
// (RQ3) Ship request with input waits for removal.
// (RQ4) Button wake needs battery above top threshold.
// (RQ5) Host may clear ship request with input.
// (RQ6) Ship mode watches only input and button.
// (RQ7) High-Z: battery powers output, others sleep.
// (RQ8) High-Z aux output follows load switch pin.
// (RQ9) Charge-disable and input select the mode.
// (RQ10) High-Z request locks serial until pin toggles.
// (RQ11) Serial enabled within 1 ms leaving High-Z.
// (RQ12) First wake hold 0.05 s to 1 s.
// (RQ13) Second wake hold 1 s to 2 s.
// (RQ14) Reset hold 8-14 s, 400 ms pulse.
// (RQ15) Zero hold time resets after 6 us.
// (RQ16) Thermistor zone changes deglitched 50 ms.
// (RQ17) Host watchdog 50 s resets serial settings.
// (RQ18) Serial logic resets after 700 ms idle.
// (RQ19) System output switches 350 us after supply.
// (RQ20) Soft start with reduced limit follows.
// (RQ21) Charge-disable pin pulled down internally.
// (RQ22) Charge-disable edges deglitched 100 us.
module pm_power_mode_controller
#(
  parameter int unsigned WAKE1_MIN_T = pm_pkg::WAKE1_MIN_MS * pm_pkg::US_PER_MS,
  parameter int unsigned WAKE1_MAX_T = pm_pkg::WAKE1_MAX_MS * pm_pkg::US_PER_MS,
  parameter int unsigned WAKE2_MIN_T = pm_pkg::WAKE2_MIN_MS * pm_pkg::US_PER_MS,
  parameter int unsigned WAKE2_MAX_T = pm_pkg::WAKE2_MAX_MS * pm_pkg::US_PER_MS,
  parameter int unsigned RESET_MIN_T = pm_pkg::RESET_MIN_S * pm_pkg::US_PER_S,
  parameter int unsigned RESET_MAX_T = pm_pkg::RESET_MAX_S * pm_pkg::US_PER_S,
  parameter int unsigned PULSE_T     = pm_pkg::RESET_PULSE_MS * pm_pkg::US_PER_MS,
  parameter int unsigned TS_DGL_T    = pm_pkg::TS_DGL_MS * pm_pkg::US_PER_MS,
  parameter int unsigned CD_DGL_T    = pm_pkg::CD_DGL_US,
  parameter int unsigned WDOG_T      = pm_pkg::WDOG_S * pm_pkg::US_PER_S,
  parameter int unsigned IDLE_T      = pm_pkg::IDLE_MS * pm_pkg::US_PER_MS
)
(
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  input  wire logic       ce_i,
  input  wire logic       charge_disable_pin_i,
  input  wire logic       pushbutton_input_n_i,
  input  wire logic       load_switch_ctrl_pin_i,
  input  wire logic       vin_above_uv_i,
  input  wire logic       bat_above_uv_i,
  input  wire logic       bat_above_max_uv_i,
  input  wire logic [2:0] thermistor_sense_zone_i,
  input  wire logic       ship_mode_request_set_i,
  input  wire logic       ship_mode_request_clr_i,
  input  wire logic       hiz_request_bit_wr_i,
  input  wire logic       aux_enable_reg_i,
  input  wire logic       wake1_sel_i,
  input  wire logic       wake2_sel_i,
  input  wire logic [1:0] reset_sel_i,
  input  wire logic       host_kick_i,
  input  wire logic       bus_activity_i,
  output logic      [2:0] mode_o,
  output logic            ship_mode_request_bit_o,
  output logic            bat_fet_on_o,
  output logic            charge_en_o,
  output logic            low_power_o,
  output logic            serial_if_en_o,
  output logic            aux_switch_regulator_output_en_o,
  output logic            charge_disable_pulldown_en_o,
  output logic            reset_out_o,
  output logic            reset_oe_n_o,
  output logic            wake1_o,
  output logic            wake2_o,
  output logic      [2:0] thermistor_zone_o,
  output logic            wdog_reset_o,
  output logic            bus_idle_reset_o,
  output logic            system_output_switch_en_o,
  output logic            soft_start_o
);

  // Short counts, in microsecond ticks, and the last prescaler cycle.
  localparam int unsigned DETECT_T = pm_pkg::DETECT_US;
  localparam int unsigned START_T  = pm_pkg::START_SYS_US;
  localparam int unsigned SOFT_END = START_T + pm_pkg::SOFTSTART_US;
  localparam logic [6:0] PRESC_LAST = 7'(pm_pkg::TICK_CYC - 1);

  // Timer slots of the generate loop.
  localparam int T_HOLD  = 0;
  localparam int T_PULSE = 1;
  localparam int T_WDOG  = 2;
  localparam int T_IDLE  = 3;
  localparam int T_START = 4;
  localparam int N_TMR   = 5;

  // Mode of the pin pair outside ship mode and the host lock.
  function automatic pm_pkg::pm_mode_type decode_mode(input logic cd,
                                                      input logic vin);
    if (vin)
      decode_mode = cd ? pm_pkg::MODE_CHGDIS : pm_pkg::MODE_CHGEN;
    else
      decode_mode = cd ? pm_pkg::MODE_ACTBAT : pm_pkg::MODE_HIZ;
  endfunction

  logic [6:0]         presc_q;      // Cycle prescaler for the tick.
  wire                tick;         // One-cycle pulse every microsecond.
  wire  [4:0]         raw_s;        // Synchronised plain pins.
  wire                cd_f;         // Deglitched charge-disable level.
  logic               cd_prev_q;    // Charge-disable level last cycle.
  wire                cd_edge;      // Charge-disable has toggled.
  wire                vin_s;        // Input supply above threshold.
  wire                bat_s;        // Battery above its threshold.
  wire                bat_max_s;    // Battery above highest threshold.
  wire                pressed;      // Push button held down.
  wire                ls_s;         // Load switch control level.
  logic               pb_prev_q;    // Button state last cycle.
  wire                released;     // Button has just been let go.
  pm_pkg::pm_mode_type mode_q;      // Current operating mode.
  pm_pkg::pm_mode_type mode_d;      // Next operating mode.
  pm_pkg::pm_mode_type norm_mode;   // Mode outside ship mode.
  logic               ship_req_q;   // Ship mode request bit.
  logic               lock_q;       // Serial port locked by High-Z write.
  wire                lock_d;       // Next lock value.
  logic               aux_kept_q;   // Aux enable held at High-Z entry.
  wire                hiz_entry;    // High-Z is entered this cycle.
  wire                ship_enter;   // Ship mode is entered this cycle.
  wire                ship_exit;    // Ship mode is left this cycle.
  wire  [31:0]        tmr_cnt [N_TMR];
  wire  [N_TMR-1:0]   tmr_clr;      // Clear of each timer.
  wire  [31:0]        wake1_thr;    // Selected first wake time.
  wire  [31:0]        wake2_thr;    // Selected second wake time.
  wire  [31:0]        rst_thr;      // Selected reset hold time.
  wire                wake1_rel;    // Release after a first-wake hold.
  wire                wake2_rel;    // Release after a second-wake hold.
  logic               fired_q;      // Reset already fired this press.
  wire                rst_fire;     // Start of a reset pulse.
  logic               pulse_q;      // Reset pulse in progress.
  wire                supply_up;    // A supply feeds the system output.
  wire                wdog_hit;     // Watchdog time has run out.
  wire                idle_hit;     // Bus has been idle too long.

  // Microsecond tick prescaler.
  assign tick = (presc_q == PRESC_LAST);
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      presc_q <= 7'h00;
    else if (ce_i)
      presc_q <= tick ? 7'h00 : presc_q + 7'h01;
  end

  // Plain pins pass three flip-flops and no filter.
  pm_filt #(.W(5), .DGL_TICKS(0), .RST(pm_pkg::RAW_RST)) u_raw (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .tick_i   (tick),
    .d_i      ({pushbutton_input_n_i, vin_above_uv_i, bat_above_uv_i,
                bat_above_max_uv_i, load_switch_ctrl_pin_i}),
    .q_o      (raw_s)
  );
  assign pressed   = ~raw_s[4];
  assign vin_s     = raw_s[3];
  assign bat_s     = raw_s[2];
  assign bat_max_s = raw_s[1];
  assign ls_s      = raw_s[0];

  // Charge-disable is deglitched on both edges.
  pm_filt #(.W(1), .DGL_TICKS(CD_DGL_T), .RST(1'b0)) u_cd ( // RQ22
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .tick_i   (tick),
    .d_i      (charge_disable_pin_i),
    .q_o      (cd_f)
  );

  // Thermistor zone changes are deglitched before they are used.
  pm_filt #(.W(3), .DGL_TICKS(TS_DGL_T), .RST(pm_pkg::TS_RST)) u_ts ( // RQ16
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .tick_i   (tick),
    .d_i      (thermistor_sense_zone_i),
    .q_o      (thermistor_zone_o)
  );

  // Timers: button hold, reset pulse, watchdog, bus idle, start-up.
  generate
    for (genvar i = 0; i < N_TMR; i++)
    begin : g_tmr
      pm_timer u_tmr (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .ce_i     (ce_i),
        .tick_i   (tick),
        .clr_i    (tmr_clr[i]),
        .cnt_o    (tmr_cnt[i])
      );
    end
  endgenerate

  // Timer clears.
  assign tmr_clr[T_HOLD]  = ~pressed;
  assign tmr_clr[T_PULSE] = ~pulse_q;
  assign tmr_clr[T_WDOG]  = host_kick_i | wdog_hit;
  assign tmr_clr[T_IDLE]  = bus_activity_i | idle_hit;
  assign tmr_clr[T_START] = ~supply_up;

  // Programmable hold thresholds.
  assign wake1_thr = wake1_sel_i ? WAKE1_MAX_T : WAKE1_MIN_T; // RQ12
  assign wake2_thr = wake2_sel_i ? WAKE2_MAX_T : WAKE2_MIN_T; // RQ13
  assign rst_thr   = (reset_sel_i == 2'h0) ? DETECT_T :       // RQ15
                     (reset_sel_i == 2'h1) ? RESET_MIN_T :    // RQ14
                     RESET_MAX_T;

  // Wake events are judged on release, with the hold still counted.
  assign released  = pb_prev_q & ~pressed;
  assign wake1_rel = released & (tmr_cnt[T_HOLD] >= wake1_thr);
  assign wake2_rel = released & (tmr_cnt[T_HOLD] >= wake2_thr);

  // Reset fires once per press; not while the part sits in ship mode.
  assign rst_fire = pressed & ~fired_q & (mode_q != pm_pkg::MODE_SHIP) &
                    (tmr_cnt[T_HOLD] >= rst_thr);                 // RQ14

  // Host timers run out.
  assign wdog_hit = tmr_cnt[T_WDOG] >= WDOG_T;                    // RQ17
  assign idle_hit = tmr_cnt[T_IDLE] >= IDLE_T;                    // RQ18

  // System output runs once a supply is up and ship mode is left.
  assign supply_up = (bat_s | vin_s) & (mode_q != pm_pkg::MODE_SHIP);

  // Mode selection. Ship mode needs the pin high and no input.
  assign cd_edge    = cd_f ^ cd_prev_q;
  assign lock_d     = (hiz_request_bit_wr_i & ~vin_s) |           // RQ10
                      (lock_q & ~cd_edge);
  assign norm_mode  = (lock_q & ~vin_s) ? pm_pkg::MODE_HIZ :
                      decode_mode(cd_f, vin_s);                   // RQ9
  assign ship_enter = ship_req_q & cd_f & ~vin_s &                // RQ3
                      (mode_q != pm_pkg::MODE_SHIP);              // RQ2
  assign ship_exit  = (mode_q == pm_pkg::MODE_SHIP) &             // RQ6
                      (vin_s | (wake1_rel & bat_max_s));          // RQ4
  assign mode_d     = ship_enter ? pm_pkg::MODE_SHIP :
                      ((mode_q == pm_pkg::MODE_SHIP) && !ship_exit) ?
                      pm_pkg::MODE_SHIP : norm_mode;              // RQ1
  assign hiz_entry  = (mode_d == pm_pkg::MODE_HIZ) &&
                      (mode_q != pm_pkg::MODE_HIZ);

  // Mode, lock and request bit; a set wins over any clear.
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mode_q     <= pm_pkg::MODE_ACTBAT;
      lock_q     <= 1'b0;
      ship_req_q <= 1'b0;
      cd_prev_q  <= 1'b0;
    end
    else if (ce_i)
    begin
      mode_q    <= mode_d;
      lock_q    <= lock_d;
      cd_prev_q <= cd_f;
      if (ship_mode_request_set_i)
        ship_req_q <= 1'b1;
      else if ((ship_mode_request_clr_i && vin_s) || ship_exit) // RQ5
        ship_req_q <= 1'b0;
    end
  end

  // Button history, reset pulse and aux enable held at High-Z entry.
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pb_prev_q  <= 1'b0;
      fired_q    <= 1'b0;
      pulse_q    <= 1'b0;
      aux_kept_q <= 1'b0;
    end
    else if (ce_i)
    begin
      pb_prev_q <= pressed;
      fired_q   <= pressed & (fired_q | rst_fire);
      if (rst_fire)
        pulse_q <= 1'b1;
      else if (tmr_cnt[T_PULSE] >= PULSE_T)
        pulse_q <= 1'b0;
      if (hiz_entry)
        aux_kept_q <= aux_enable_reg_i;                           // RQ8
    end
  end

  // Registered outputs.
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mode_o                           <= pm_pkg::MODE_ACTBAT;
      bat_fet_on_o                     <= 1'b1;
      charge_en_o                      <= 1'b0;
      low_power_o                      <= 1'b0;
      serial_if_en_o                   <= 1'b1;
      aux_switch_regulator_output_en_o <= 1'b0;
      wake1_o                          <= 1'b0;
      wake2_o                          <= 1'b0;
      wdog_reset_o                     <= 1'b0;
      bus_idle_reset_o                 <= 1'b0;
      system_output_switch_en_o        <= 1'b0;
      soft_start_o                     <= 1'b0;
    end
    else if (ce_i)
    begin
      mode_o         <= mode_d;
      bat_fet_on_o   <= (mode_d != pm_pkg::MODE_SHIP);            // RQ1
      charge_en_o    <= (mode_d == pm_pkg::MODE_CHGEN);           // RQ9
      low_power_o    <= (mode_d == pm_pkg::MODE_HIZ) ||           // RQ7
                        (mode_d == pm_pkg::MODE_SHIP);
      serial_if_en_o <= (mode_d != pm_pkg::MODE_SHIP) &&          // RQ11
                        !(lock_d && !vin_s);
      if (mode_d == pm_pkg::MODE_SHIP)
        aux_switch_regulator_output_en_o <= 1'b0;
      else if (mode_d == pm_pkg::MODE_HIZ)
        aux_switch_regulator_output_en_o <= ls_s |                // RQ8
          (hiz_entry ? aux_enable_reg_i : aux_kept_q);
      else
        aux_switch_regulator_output_en_o <= aux_enable_reg_i;
      wake1_o          <= wake1_rel;                              // RQ12
      wake2_o          <= wake2_rel & (mode_q != pm_pkg::MODE_SHIP);
      wdog_reset_o     <= wdog_hit;                               // RQ17
      bus_idle_reset_o <= idle_hit;                               // RQ18
      system_output_switch_en_o <= supply_up &                    // RQ19
                                   (tmr_cnt[T_START] >= START_T);
      soft_start_o <= supply_up & (tmr_cnt[T_START] >= START_T) & // RQ20
                      (tmr_cnt[T_START] < SOFT_END);
    end
  end

  // Open-drain reset drives low while the pulse runs.
  assign reset_out_o  = 1'b0;
  assign reset_oe_n_o = ~pulse_q;                                 // RQ14
  assign ship_mode_request_bit_o = ship_req_q;
  assign charge_disable_pulldown_en_o = 1'b1;                     // RQ21

  // Checks on the mode logic, timers and outputs.
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i || !ce_i);

  ship_latch_a: assert property ( // RQ1
    (mode_q == pm_pkg::MODE_SHIP && !vin_s && !released)
    |=> mode_q == pm_pkg::MODE_SHIP)
    else $error("ship mode left without a wake cause");
  ship_vin_a: assert property ( // RQ3
    (mode_q != pm_pkg::MODE_SHIP && vin_s)
    |=> mode_q != pm_pkg::MODE_SHIP)
    else $error("ship mode entered with input present");
  ship_batlow_a: assert property ( // RQ4
    (mode_q == pm_pkg::MODE_SHIP && !vin_s && !bat_max_s)
    |=> mode_q == pm_pkg::MODE_SHIP)
    else $error("ship mode left with low battery");
  ship_clear_a: assert property ( // RQ5
    (ship_mode_request_clr_i && vin_s && !ship_mode_request_set_i)
    |=> !ship_mode_request_bit_o)
    else $error("ship request not cleared");
  cd_decode_a: assert property ( // RQ9
    (mode_q != pm_pkg::MODE_SHIP && !ship_req_q && !lock_q)
    |=> mode_q == decode_mode($past(cd_f), $past(vin_s)))
    else $error("mode does not match pin decode");
  hiz_lock_a: assert property ( // RQ10
    (lock_q && !vin_s && !cd_edge) |=> (lock_q && !serial_if_en_o))
    else $error("serial port unlocked without pin toggle");
  hiz_exit_a: assert property ( // RQ11
    ($past(mode_q) == pm_pkg::MODE_HIZ &&
     mode_q == pm_pkg::MODE_ACTBAT && !lock_q) |-> ##[0:1] serial_if_en_o)
    else $error("serial port not enabled leaving high-z");
  aux_follow_a: assert property ( // RQ8
    (mode_q == pm_pkg::MODE_HIZ && $past(mode_q) == pm_pkg::MODE_HIZ)
    |-> aux_switch_regulator_output_en_o == ($past(ls_s) | aux_kept_q))
    else $error("aux output does not follow load switch pin");
  reset_width_a: assert property ( // RQ14
    $fell(pulse_q) |-> $past(tmr_cnt[T_PULSE]) >= PULSE_T)
    else $error("reset pulse too short");
  reset_fast_a: assert property ( // RQ15
    ($rose(pressed) && reset_sel_i == 2'h0 && !fired_q &&
     mode_q != pm_pkg::MODE_SHIP) |-> ##[1:800] !reset_oe_n_o)
    else $error("zero hold reset not issued in time");
  sys_start_a: assert property ( // RQ19
    $rose(system_output_switch_en_o) |-> $past(tmr_cnt[T_START]) >= START_T)
    else $error("system output started too early");

endmodule

// ---- core/pm_pkg.sv ----
// Shared constants and mode type of the power mode controller.
package pm_pkg;

  // Clock rate and the one-microsecond tick that all timers count.
  localparam int unsigned CLK_MHZ   = 100;
  localparam int unsigned TICK_CYC  = CLK_MHZ;
  localparam int unsigned US_PER_MS = 1000;
  localparam int unsigned US_PER_S  = 1000000;

  // Push-button hold times, programmable between least and most.
  localparam int unsigned WAKE1_MIN_MS = 50;
  localparam int unsigned WAKE1_MAX_MS = 1000;
  localparam int unsigned WAKE2_MIN_MS = 1000;
  localparam int unsigned WAKE2_MAX_MS = 2000;
  localparam int unsigned RESET_MIN_S  = 8;
  localparam int unsigned RESET_MAX_S  = 14;

  // Reset pulse width and the detection delay for a zero hold time.
  localparam int unsigned RESET_PULSE_MS = 400;
  localparam int unsigned DETECT_US      = 6;

  // Deglitch, watchdog and inactivity times.
  localparam int unsigned TS_DGL_MS = 50;
  localparam int unsigned CD_DGL_US = 100;
  localparam int unsigned WDOG_S    = 50;
  localparam int unsigned IDLE_MS   = 700;

  // System output start-up delay and soft-start length.
  localparam int unsigned START_SYS_US = 350;
  localparam int unsigned SOFTSTART_US = 400;

  // Reset values of the synchronised pins.
  localparam logic [4:0] RAW_RST = 5'h10;
  localparam logic [2:0] TS_RST  = 3'h0;

  // Operating modes of the device.
  typedef enum logic [2:0] {
    MODE_SHIP   = 3'b000,
    MODE_HIZ    = 3'b001,
    MODE_ACTBAT = 3'b010,
    MODE_CHGEN  = 3'b011,
    MODE_CHGDIS = 3'b100
  } pm_mode_type;

endpackage

// ---- core/pm_filt.sv ----
// Two-stage synchroniser followed by a stability deglitch filter.
`timescale 1ns/1ns
module pm_filt
#(
  parameter int unsigned W         = 1,
  parameter int unsigned DGL_TICKS = 0,
  parameter logic [W-1:0] RST      = '0
)
(
  input  wire logic         mclk_i,
  input  wire logic         resetn_i,
  input  wire logic         ce_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_q;   // First stage, read only by the second.
  logic [W-1:0] s2_q;   // Second stage, safe to use.
  logic [31:0]  cnt_q;  // Ticks the new value has been stable.

  // Synchroniser; both stages take the reset value.
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s1_q <= RST;
      s2_q <= RST;
    end
    else if (ce_i)
    begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end

  // A change is accepted only after it has held for DGL_TICKS ticks.
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      q_o   <= RST;
      cnt_q <= 32'h0;
    end
    else if (ce_i)
    begin
      if (s2_q == q_o)
        cnt_q <= 32'h0;
      else if (DGL_TICKS == 0)
        q_o <= s2_q;
      else if (tick_i)
      begin
        if (cnt_q + 32'h1 >= DGL_TICKS)
        begin
          q_o   <= s2_q;
          cnt_q <= 32'h0;
        end
        else
          cnt_q <= cnt_q + 32'h1;
      end
    end
  end

endmodule

// ---- core/pm_timer.sv ----
// Saturating microsecond tick counter with synchronous clear.
`timescale 1ns/1ns
module pm_timer
(
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  input  wire logic        tick_i,
  input  wire logic        clr_i,
  output logic      [31:0] cnt_o
);

  // Clear has priority; the count stops at its top value.
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cnt_o <= 32'h0;
    else if (ce_i)
    begin
      if (clr_i)
        cnt_o <= 32'h0;
      else if (tick_i && cnt_o != 32'hFFFFFFFF)
        cnt_o <= cnt_o + 32'h1;
    end
  end

endmodule

// ---- tb/pm_partner.sv ----
// Push-button and supply detection model beside the controller.
`timescale 1ns/1ns
module pm_partner
(
  input  wire logic mclk_i,
  input  wire logic press_i,
  input  wire logic vin_i,
  input  wire logic cd_hi_i,
  output logic      pushbutton_input_n_o,
  output logic      vin_above_uv_o,
  output logic      charge_disable_pin_o
);
  // Pins start released, input absent and charge-disable high.
  initial
  begin
    pushbutton_input_n_o = 1'b1;
    vin_above_uv_o       = 1'b0;
    charge_disable_pin_o = 1'b1;
  end
  // The pulled-up button reads low while pressed; host raises cd for ship.
  always @(posedge mclk_i)
  begin
    pushbutton_input_n_o <= ~press_i;
    vin_above_uv_o       <= vin_i;
    charge_disable_pin_o <= cd_hi_i;
  end
endmodule

// ---- tb/tb_pm_power_mode_controller.sv ----
// Self-checking bench of the power mode controller.
`timescale 1ns/1ns
module tb_pm_power_mode_controller;
  logic mclk_i = 0, resetn_i = 0, press = 0, vin = 0, cd = 1, pb_n, vin_s, cd_s;
  logic lsc = 0, set = 0, clr = 0, hzw = 0, w1 = 0;
  logic ce = 1, bat = 0, batmx = 1, auxen = 0, w2 = 0, kick = 0, act = 0;
  logic pd, ro;
  // Shortened timer lengths, in microsecond ticks.
  localparam int unsigned P_W1A = 5, P_W1B = 20, P_W2A = 20, P_W2B = 40;
  localparam int unsigned P_RSA = 80, P_RSB = 140, P_PLS = 40, P_TSD = 5;
  localparam int unsigned P_CDD = 3, P_WDG = 50, P_IDL = 30;
  logic [1:0] rsel = 2'h1;
  logic [2:0] zone = 3'h0, mode, tz;
  logic shb, fet, chg, lp, ser, aux, rst_n, wk1, wk2, wd, idl, swe, ss;
  int err_count = 0, compares = 0, n;
  // The clock toggles every half period of 5 ns.
  always #5 mclk_i = ~mclk_i;
  pm_partner pm_partner_inst (.mclk_i(mclk_i), .press_i(press), .vin_i(vin),
    .cd_hi_i(cd), .pushbutton_input_n_o(pb_n), .vin_above_uv_o(vin_s),
    .charge_disable_pin_o(cd_s));
  pm_power_mode_controller #(.WAKE1_MIN_T(P_W1A), .WAKE1_MAX_T(P_W1B),
    .WAKE2_MIN_T(P_W2A), .WAKE2_MAX_T(P_W2B), .RESET_MIN_T(P_RSA),
    .RESET_MAX_T(P_RSB), .PULSE_T(P_PLS), .TS_DGL_T(P_TSD),
    .CD_DGL_T(P_CDD), .WDOG_T(P_WDG), .IDLE_T(P_IDL))
  pm_power_mode_controller_inst (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .ce_i(ce), .charge_disable_pin_i(cd_s), .pushbutton_input_n_i(pb_n),
    .load_switch_ctrl_pin_i(lsc), .vin_above_uv_i(vin_s),
    .bat_above_uv_i(bat), .bat_above_max_uv_i(batmx),
    .thermistor_sense_zone_i(zone), .ship_mode_request_set_i(set),
    .ship_mode_request_clr_i(clr), .hiz_request_bit_wr_i(hzw),
    .aux_enable_reg_i(auxen), .wake1_sel_i(w1), .wake2_sel_i(w2),
    .reset_sel_i(rsel), .host_kick_i(kick), .bus_activity_i(act),
    .mode_o(mode), .ship_mode_request_bit_o(shb), .bat_fet_on_o(fet),
    .charge_en_o(chg), .low_power_o(lp), .serial_if_en_o(ser),
    .aux_switch_regulator_output_en_o(aux),
    .charge_disable_pulldown_en_o(pd), .reset_out_o(ro), .reset_oe_n_o(rst_n),
    .wake1_o(wk1), .wake2_o(wk2), .thermistor_zone_o(tz),
    .wdog_reset_o(wd), .bus_idle_reset_o(idl),
    .system_output_switch_en_o(swe), .soft_start_o(ss));
  // Waits c rising edges, then lets their updates settle.
  task automatic wt(input int c);
    repeat (c) @(posedge mclk_i);
    #1;
  endtask
  // Compares one value and reports a mismatch.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Counts cycles until the chosen output reads the given level.
  task automatic cnt(input int s, input logic v, input int lim);
    for (n = 0; n < lim && (s == 0 ? swe : s == 1 ? rst_n : s == 2 ? idl :
         s == 3 ? wd : wk1) !== v; n++)
      wt(1);
  endtask
  // Every cd and input pairing selects its mode.
  task automatic t_decode();
    logic [2:0] ex [4] = '{pm_pkg::MODE_HIZ, pm_pkg::MODE_ACTBAT,
                           pm_pkg::MODE_CHGEN, pm_pkg::MODE_CHGDIS};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk_i);
      cd <= i[0];
      vin <= i[1];
      wt(700);
      chk(16'(mode), 16'(ex[i]));
      chk(16'(chg), 16'(i == 2));
    end
  endtask
  // Ship request waits for input removal; a button wake leaves ship.
  task automatic t_ship();
    @(posedge mclk_i);
    set <= 1;
    @(posedge mclk_i);
    set <= 0;
    clr <= 1;
    @(posedge mclk_i);
    clr <= 0;
    set <= 1;
    @(posedge mclk_i);
    set <= 0;
    wt(3);
    chk(16'({shb, mode}), 16'({1'b1, pm_pkg::MODE_CHGDIS}));
    @(posedge mclk_i);
    vin <= 0;
    wt(10);
    chk(16'({fet, lp, mode}), 16'({2'b01, pm_pkg::MODE_SHIP}));
    // A wake press with a low battery must leave the part in ship mode.
    @(posedge mclk_i);
    batmx <= 0;
    press <= 1;
    wt(800);
    @(posedge mclk_i);
    press <= 0;
    wt(10);
    chk(16'(mode), 16'(pm_pkg::MODE_SHIP));
    @(posedge mclk_i);
    batmx <= 1;
    @(posedge mclk_i);
    press <= 1;
    wt(800);
    chk(16'(mode), 16'(pm_pkg::MODE_SHIP));
    @(posedge mclk_i);
    press <= 0;
    wt(10);
    chk(16'({shb, mode}), 16'({1'b0, pm_pkg::MODE_ACTBAT}));
  endtask
  // Zero hold time gives a reset pulse of the set length.
  task automatic t_reset();
    @(posedge mclk_i);
    rsel <= 2'h0;
    press <= 1;
    cnt(1, 0, 1000);
    chk(16'(n > 500 && n < 700), 16'h1);
    cnt(1, 1, 5000);
    chk(16'(n > 3850 && n < 4150), 16'h1);
    @(posedge mclk_i);
    press <= 0;
  endtask
  // A release after a 25 tick hold gives wake pulses per selected time.
  task automatic t_wake(input logic s2, input logic e2);
    @(posedge mclk_i);
    rsel <= 2'h1;
    w1 <= 1;
    w2 <= s2;
    press <= 1;
    wt(2500);
    @(posedge mclk_i);
    press <= 0;
    cnt(4, 1, 20);
    chk(16'(wk1), 16'h1);
    chk(16'(wk2), 16'(e2));
  endtask
  // High-Z request locks the serial interface until cd toggles.
  task automatic t_hiz();
    @(posedge mclk_i);
    hzw <= 1;
    @(posedge mclk_i);
    hzw <= 0;
    wt(3);
    chk(16'(ser), 16'h0);
    @(posedge mclk_i);
    cd <= 0;
    lsc <= 1;
    wt(700);
    chk(16'(aux), 16'h1);
    @(posedge mclk_i);
    cd <= 1;
    wt(700);
    chk(16'({ser, mode}), 16'({1'b1, pm_pkg::MODE_ACTBAT}));
    // Aux enabled by the host before High-Z entry must stay on.
    @(posedge mclk_i);
    lsc <= 0;
    auxen <= 1;
    cd <= 0;
    wt(700);
    @(posedge mclk_i);
    auxen <= 0;
    wt(5);
    chk(16'(aux), 16'h1);
    @(posedge mclk_i);
    cd <= 1;
    wt(700);
  endtask
  // A low clock enable freezes the mode against a pin change.
  task automatic t_ce();
    @(posedge mclk_i);
    ce <= 0;
    cd <= 0;
    wt(700);
    chk(16'(mode), 16'(pm_pkg::MODE_ACTBAT));
    @(posedge mclk_i);
    cd <= 1;
    wt(5);
    @(posedge mclk_i);
    ce <= 1;
  endtask
  // Timers, thermistor deglitch, bus idle and watchdog.
  task automatic t_timers();
    @(posedge mclk_i);
    zone <= 3'h3;
    wt(200);
    chk(16'(tz), 16'h0);
    wt(600);
    chk(16'(tz), 16'h3);
    cnt(2, 1, 4000);
    wt(1);
    cnt(2, 1, 4000);
    chk(16'(n > 2900 && n < 3100), 16'h1);
    cnt(3, 1, 6000);
    chk(16'(wd), 16'h1);
    // Host kick and bus activity restart both timers.
    cnt(2, 1, 4000);
    wt(1500);
    @(posedge mclk_i);
    kick <= 1;
    act <= 1;
    @(posedge mclk_i);
    kick <= 0;
    act <= 0;
    cnt(2, 1, 4000);
    chk(16'(n > 2850 && n < 3050), 16'h1);
    cnt(3, 1, 6000);
    chk(16'(n > 1900 && n < 2100), 16'h1);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog cuts a hung run short.
  initial
  begin
    #1000000;
    err_count++;
    tally_and_finish();
  end
  // Main sequence.
  initial
  begin
    repeat (5) @(posedge mclk_i);
    resetn_i <= 1;
    bat <= 1;
    cnt(0, 1, 40000);
    chk(16'(n > 34500 && n < 35500), 16'h1);
    chk(16'(ss), 16'h1);
    chk(16'({pd, ro}), 16'h2);
    t_decode();
    t_ship();
    t_reset();
    t_wake(1'b0, 1'b1);
    t_wake(1'b1, 1'b0);
    t_hiz();
    t_ce();
    t_timers();
    tally_and_finish();
  end
endmodule
